// file: lpp_port.sv
/*
 * Latched parallel port: one input byte, one output byte at a data
 * address and a two-bit status at the next address, reached by plain
 * I/O read and write strobes. Assumes a one-cycle io_rd/io_wr pulse per
 * access from logic on the same clock; pins come from outside the domain.
 */
// Overview of operation
// RL1 - Data at base plus 2, status plus 3
// RL2 - Status bit0 available, bit1 taken, rest zero
// RL3 - Eight input lines, eight output lines
// RL4 - No programming; switches and jumpers only
// RL5 - Strobe captures input, sets available flag
// RL6 - Edge latch polarity follows strobe select
// RL7 - Transparent during pulse, held at its end
// RL8 - Open strobe with select on: always live
// RL9 - Output enable drives data, clears attention
// RL10 - Enable polarity follows its select switch
// RL11 - Attention: level high/low, pulse high/low
// RL12 - Level mode: write while disabled asserts attention
// RL13 - Level mode: enabling returns attention inactive
// RL14 - Attention state readable via status
// RL15 - Pulse mode: pulse as wide as write
// RL16 - Peripheral keeps outputs enabled in pulse mode
// RL17 - Data read clears available; irq follows it
// RL18 - Reset leaves flags and attention inactive
`timescale 1ns/100ps
module lpp_port (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [1:0] io_addr,
  input wire logic io_rd,
  input wire logic io_wr,
  input wire logic io_wr_strobe,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  input wire logic strobe_polarity_select,
  input wire logic output_enable_polarity_select,
  input wire logic [1:0] attention_style_jumper,
  input wire logic [1:0] latch_style_select,
  input wire logic [7:0] par_in,
  input wire logic par_strobe,
  input wire logic par_oe,
  output logic [7:0] par_out,
  output logic par_out_oe,
  output logic attention,
  output logic input_irq
);

  logic strobe_clean;
  logic oe_clean;
  logic [7:0] in_clean;
  logic strobe_d_r;
  logic oe_on_d_r;
  logic [7:0] in_data_r;
  logic [7:0] out_data_r;
  logic input_available_flag_r;
  logic output_taken_flag_r;
  logic attn_flag_r;
  logic attn_level;
  logic [2:0] settle_cnt_r;
  logic settled;
  logic strobe_active;
  logic strobe_edge;
  logic strobe_end;
  logic oe_on;
  logic oe_rise;
  logic data_wr;
  logic data_rd;
  logic status_rd;
  logic transparent;
  logic attn_pulse_mode;
  logic attn_low_style;
  logic [7:0] in_view;
  lpp_pkg::lpp_latch_e latch_style;
  lpp_pkg::lpp_attn_e attn_style;

  lpp_sync_if strobe_if ();
  lpp_sync_if oe_if ();
  lpp_sync_if in_if [lpp_pkg::LPP_DW] ();

  // Control pins pass the three-flop filter
  assign strobe_if.raw = par_strobe;
  assign oe_if.raw = par_oe;
  assign strobe_clean = strobe_if.clean;
  assign oe_clean = oe_if.clean;

  lpp_sync #(.RST_VAL(1'b0)) u_sync_strobe (
    .clock(clock),
    .resetn(resetn),
    .sig(strobe_if)
  );

  lpp_sync #(.RST_VAL(1'b0)) u_sync_oe (
    .clock(clock),
    .resetn(resetn),
    .sig(oe_if)
  );

  // One filter per input data line
  for (genvar gi = 0; gi < lpp_pkg::LPP_DW; gi++) begin : g_in
    assign in_if[gi].raw = par_in[gi];
    assign in_clean[gi] = in_if[gi].clean;
    lpp_sync #(.RST_VAL(1'b0)) u_sync_in (
      .clock(clock),
      .resetn(resetn),
      .sig(in_if[gi])
    );
  end

  // Switch and jumper decode; no software mode setting exists [RL4]
  assign latch_style = lpp_pkg::lpp_latch_e'(latch_style_select);
  assign attn_style = lpp_pkg::lpp_attn_e'(attention_style_jumper);
  assign attn_pulse_mode = (attn_style == lpp_pkg::LPP_ATTN_PULSE_HI) ||
                           (attn_style == lpp_pkg::LPP_ATTN_PULSE_LO);
  assign attn_low_style = (attn_style == lpp_pkg::LPP_ATTN_LEVEL_LO) ||
                          (attn_style == lpp_pkg::LPP_ATTN_PULSE_LO);

  // Strobe active level follows the polarity select [RL6] [RL7]
  assign strobe_active = strobe_polarity_select ? strobe_clean : ~strobe_clean;
  // Capturing edge: rising of the active level in edge mode [RL6]
  assign strobe_edge = settled & strobe_active & ~strobe_d_r;
  // Pulse end: active level just dropped [RL7]
  assign strobe_end = settled & ~strobe_active & strobe_d_r;

  // Output enable decode: low enables with select on [RL10]
  assign oe_on = output_enable_polarity_select ? ~oe_clean : oe_clean;
  assign oe_rise = settled & oe_on & ~oe_on_d_r;

  // Filters start from their reset level, not the pin's idle level, so the
  // first edges after reset are false; a strobe in that window is not counted
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      settle_cnt_r <= 3'h0;
    end else if (settle_cnt_r != lpp_pkg::LPP_SETTLE_CYC) begin
      settle_cnt_r <= settle_cnt_r + 3'h1;
    end
  end
  assign settled = (settle_cnt_r == lpp_pkg::LPP_SETTLE_CYC); // [RL18]

  // Bus decode at the two documented offsets [RL1]
  assign data_wr = io_wr && (io_addr == lpp_pkg::LPP_OFS_DATA);
  assign data_rd = io_rd && (io_addr == lpp_pkg::LPP_OFS_DATA);
  assign status_rd = io_rd && (io_addr == lpp_pkg::LPP_OFS_STATUS);

  // Live data shown while transparent [RL7] [RL8]
  always_comb begin
    transparent = 1'b0;
    unique case (latch_style)
      lpp_pkg::LPP_LATCH_EDGE: transparent = 1'b0;
      lpp_pkg::LPP_LATCH_TRANSP_PULSE: transparent = strobe_active;
      lpp_pkg::LPP_LATCH_TRANSP_FULL: transparent = 1'b1;
      default: transparent = 1'b1;
    endcase
  end
  assign in_view = transparent ? in_clean : in_data_r;

  // Edge history of strobe and enable
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      strobe_d_r <= 1'b0;
      oe_on_d_r <= 1'b0;
    end else begin
      strobe_d_r <= strobe_active;
      oe_on_d_r <= oe_on;
    end
  end

  // Input register: capture on edge or on each cycle of the pulse [RL3] [RL5] [RL6] [RL7]
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      in_data_r <= lpp_pkg::LPP_DATA_RST;
    end else if (latch_style == lpp_pkg::LPP_LATCH_EDGE && strobe_edge) begin
      in_data_r <= in_clean;
    end else if (latch_style == lpp_pkg::LPP_LATCH_TRANSP_PULSE && strobe_active &&
                 settled) begin
      in_data_r <= in_clean;
    end
  end

  // Available flag: set by a strobe, cleared by a data read; set wins
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      input_available_flag_r <= lpp_pkg::LPP_FLAG_RST; // [RL18]
    end else if ((latch_style == lpp_pkg::LPP_LATCH_EDGE && strobe_edge) ||
                 (latch_style == lpp_pkg::LPP_LATCH_TRANSP_PULSE && strobe_end)) begin
      input_available_flag_r <= 1'b1; // [RL5]
    end else if (data_rd) begin
      input_available_flag_r <= 1'b0; // [RL17]
    end
  end

  // Output register written by the processor [RL3]
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      out_data_r <= lpp_pkg::LPP_DATA_RST;
    end else if (data_wr) begin
      out_data_r <= io_wdata;
    end
  end

  // Attention flag for level styles: write sets, enabling clears [RL12] [RL13]
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      attn_flag_r <= lpp_pkg::LPP_FLAG_RST; // [RL18]
    end else if (attn_pulse_mode) begin
      attn_flag_r <= 1'b0;
    end else if (data_wr && !oe_on) begin
      attn_flag_r <= 1'b1; // [RL12]
    end else if (oe_rise) begin
      attn_flag_r <= 1'b0; // [RL9] [RL13]
    end
  end

  // Taken flag: set when an enable clears pending attention, cleared by a new write
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      output_taken_flag_r <= lpp_pkg::LPP_FLAG_RST; // [RL18]
    end else if (oe_rise && attn_flag_r) begin
      output_taken_flag_r <= 1'b1; // [RL9]
    end else if (data_wr) begin
      output_taken_flag_r <= 1'b0;
    end
  end

  // Attention pin: level from the flag, or pulse as wide as the write strobe
  always_comb begin
    attn_level = attn_pulse_mode ? io_wr_strobe : attn_flag_r; // [RL11] [RL15]
    attention = attn_low_style ? ~attn_level : attn_level; // [RL11] [RL18]
  end

  // Output drivers follow the decoded enable; pulse use expects it held on
  assign par_out = out_data_r;
  assign par_out_oe = oe_on; // [RL9] [RL10] [RL16]

  // Read data: input byte or status; taken shows attention cleared [RL2] [RL14]
  always_comb begin
    io_rdata = 8'h00;
    if (io_addr == lpp_pkg::LPP_OFS_DATA) begin
      io_rdata = in_view; // [RL8]
    end else if (io_addr == lpp_pkg::LPP_OFS_STATUS) begin
      io_rdata[lpp_pkg::LPP_ST_AVAIL] = input_available_flag_r; // [RL2]
      io_rdata[lpp_pkg::LPP_ST_TAKEN] = output_taken_flag_r; // [RL2] [RL14]
    end
  end

  // Input interrupt request while data waits [RL17]
  assign input_irq = input_available_flag_r;

endmodule : lpp_port

// file: lpp_pkg.sv
/*
 * Package for the latched parallel port: register offsets, status bit
 * positions, attention styles and the reset values of the port state.
 * Assumes a single 200 MHz clock domain and nothing else.
 */
package lpp_pkg;

  // Register offsets within the channel address group
  localparam logic [1:0] LPP_OFS_DATA = 2'h2;
  localparam logic [1:0] LPP_OFS_STATUS = 2'h3;

  // Status bit positions
  localparam int LPP_ST_AVAIL = 0;
  localparam int LPP_ST_TAKEN = 1;

  // Data width of each direction
  localparam int LPP_DW = 8;

  // Reset values
  localparam logic [7:0] LPP_DATA_RST = 8'h00;
  localparam logic LPP_FLAG_RST = 1'b0;

  // Cycles after reset before pin edges count: filter depth plus edge history
  localparam logic [2:0] LPP_SETTLE_CYC = 3'h5;

  // Attention style jumper encodings
  typedef enum logic [1:0] {
    LPP_ATTN_LEVEL_HI,
    LPP_ATTN_LEVEL_LO,
    LPP_ATTN_PULSE_HI,
    LPP_ATTN_PULSE_LO
  } lpp_attn_e;

  // Input latch styles
  typedef enum logic [1:0] {
    LPP_LATCH_EDGE,
    LPP_LATCH_TRANSP_PULSE,
    LPP_LATCH_TRANSP_FULL
  } lpp_latch_e;

  // Host write strobe span, ns, bounding the attention pulse width
  localparam int LPP_CLK_NS = 5;
  localparam int LPP_WR_MIN_NS = 150;
  localparam int LPP_WR_MAX_NS = 1000;
  localparam int LPP_WR_MIN_CYC = (LPP_WR_MIN_NS + LPP_CLK_NS - 1) / LPP_CLK_NS;
  localparam int LPP_WR_MAX_CYC = LPP_WR_MAX_NS / LPP_CLK_NS;

endpackage : lpp_pkg

// file: lpp_sync_if.sv
/*
 * Interface carrying one pin through the three-stage input synchroniser.
 * Assumes the raw level may change at any time relative to clock.
 */
`timescale 1ns/100ps
interface lpp_sync_if;
  logic raw;
  logic clean;
  modport syncer (input raw, output clean);
  modport user (output raw, input clean);
endinterface : lpp_sync_if

// file: lpp_sync.sv
/*
 * Three-flop synchroniser with agreement filter for one pin.
 * Assumes clock at 200 MHz and an asynchronous active-low reset.
 */
`timescale 1ns/100ps
module lpp_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic clock,
  input wire logic resetn,
  lpp_sync_if.syncer sig
);

  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic clean_r;

  // Shift chain; only the second stage reads the first
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s1_r <= RST_VAL;
      s2_r <= RST_VAL;
      s3_r <= RST_VAL;
    end else begin
      s1_r <= sig.raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Accept a change once stages two and three agree
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      clean_r <= RST_VAL;
    end else if (s2_r == s3_r) begin
      clean_r <= s2_r;
    end
  end

  assign sig.clean = clean_r;

endmodule : lpp_sync

// file: lpp_port_properties.sv
/* Port-level properties of the latched parallel port.
   Bound to lpp_port; sees only its ports, single clock domain. */
`timescale 1ns/100ps
module lpp_port_checker (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [1:0] io_addr,
  input wire logic io_rd,
  input wire logic io_wr,
  input wire logic io_wr_strobe,
  input wire logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata,
  input wire logic output_enable_polarity_select,
  input wire logic [1:0] attention_style_jumper,
  input wire logic par_oe,
  input wire logic [7:0] par_out,
  input wire logic par_out_oe,
  input wire logic attention,
  input wire logic input_irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  // Status layout and read side effects
  a_status_zero: assert property (io_addr == lpp_pkg::LPP_OFS_STATUS
      |-> io_rdata[7:2] == 6'h00)
    else $error("status upper bits not zero");
  a_avail_irq: assert property (io_addr == lpp_pkg::LPP_OFS_STATUS
      |-> io_rdata[0] == input_irq)
    else $error("available bit differs from irq");
  a_read_clears: assert property ($fell(input_irq)
      |-> $past(io_rd && io_addr == lpp_pkg::LPP_OFS_DATA))
    else $error("available dropped without data read");
  // Output register loading
  a_write_loads: assert property (io_wr && io_addr == lpp_pkg::LPP_OFS_DATA
      |=> par_out == $past(io_wdata))
    else $error("output byte not loaded");
  a_other_ignored: assert property (io_wr && io_addr != lpp_pkg::LPP_OFS_DATA
      |=> $stable(par_out))
    else $error("write elsewhere changed output");
  // Attention behaviour per style, and output enable polarity
  a_level_raise: assert property (!attention_style_jumper[1] && io_wr && !par_out_oe
      && io_addr == lpp_pkg::LPP_OFS_DATA |=> attention != attention_style_jumper[0])
    else $error("attention not raised by write");
  a_level_clear: assert property ($rose(par_out_oe) && !attention_style_jumper[1]
      |-> ##[0:1] attention == attention_style_jumper[0])
    else $error("attention not cleared by enable");
  a_pulse_width: assert property (attention_style_jumper[1]
      |-> attention == (io_wr_strobe ^ attention_style_jumper[0]))
    else $error("attention pulse does not follow write strobe");
  a_oe_polarity: assert property ($stable(par_oe) [*8]
      |-> par_out_oe == (par_oe ^ output_enable_polarity_select))
    else $error("output enable polarity wrong");
  // Quiet start after every reset release, whatever the idle pin levels
  a_reset_inactive: assert property ($rose(resetn)
      |-> attention == attention_style_jumper[0])
    else $error("attention active after reset");
  a_reset_quiet: assert property ($rose(resetn)
      |-> !input_irq [*6])
    else $error("available set before any strobe");
endmodule : lpp_port_checker

bind lpp_port lpp_port_checker chk_u (.clock(clock), .resetn(resetn), .io_addr(io_addr),
  .io_rd(io_rd), .io_wr(io_wr), .io_wr_strobe(io_wr_strobe), .io_wdata(io_wdata),
  .io_rdata(io_rdata), .output_enable_polarity_select(output_enable_polarity_select),
  .attention_style_jumper(attention_style_jumper), .par_oe(par_oe), .par_out(par_out),
  .par_out_oe(par_out_oe), .attention(attention), .input_irq(input_irq));

// file: lpp_periph.sv
/* Model of the external peripheral: strobes bytes in, enables outputs.
   Assumes tasks are called from the bench on the port clock. */
`timescale 1ns/100ps
module lpp_periph (
  input wire logic clock,
  input wire logic strobe_pol,
  input wire logic oe_pol,
  output logic [7:0] par_in,
  output logic par_strobe,
  output logic par_oe
);
  // Lines idle until commanded
  initial begin
    par_in = 8'h00;
    par_strobe = 1'h0;
    par_oe = 1'h1;
  end
  // Strobe inactive, outputs left tri-stated
  task idle;
    par_strobe <= !strobe_pol;
    par_oe <= oe_pol;
  endtask : idle
  task drive(input logic [7:0] d);
    @(posedge clock);
    par_in <= d;
  endtask : drive
  // Data steady around both strobe edges, then lines flipped once hold expires
  task send(input logic [7:0] d);
    drive(d);
    repeat (6) @(posedge clock);
    par_strobe <= strobe_pol;
    repeat (6) @(posedge clock);
    par_strobe <= !strobe_pol;
    repeat (6) @(posedge clock);
    par_in <= ~d;
  endtask : send
  // Enable takes the data; held on for pulse styles
  task enable(input logic on);
    @(posedge clock);
    par_oe <= on ? !oe_pol : oe_pol;
  endtask : enable
endmodule : lpp_periph

// file: lpp_port_tb.sv
/* Self-checking bench for the latched parallel port.
   Assumes lpp_port, its checker and the peripheral model are compiled. */
`timescale 1ns/100ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fail_count++; \
  $display("[FAIL] %0t got %h expected %h", $time, g, e); end end
module lpp_port_tb;
  logic clock, resetn, io_rd, io_wr, io_wr_strobe, strobe_sel, oe_sel, par_strobe, par_oe;
  logic par_out_oe, attention, input_irq, attn_mid;
  logic [1:0] io_addr, attn_sel, latch_sel;
  logic [7:0] io_wdata, io_rdata, par_in, par_out, rd_v;
  int fail_count, compares;
  lpp_port dut_u (.clock(clock), .resetn(resetn), .io_addr(io_addr), .io_rd(io_rd),
    .io_wr(io_wr), .io_wr_strobe(io_wr_strobe), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .strobe_polarity_select(strobe_sel), .output_enable_polarity_select(oe_sel),
    .attention_style_jumper(attn_sel), .latch_style_select(latch_sel), .par_in(par_in),
    .par_strobe(par_strobe), .par_oe(par_oe), .par_out(par_out), .par_out_oe(par_out_oe),
    .attention(attention), .input_irq(input_irq));
  lpp_periph periph_u (.clock(clock), .strobe_pol(strobe_sel), .oe_pol(oe_sel),
    .par_in(par_in), .par_strobe(par_strobe), .par_oe(par_oe));
  // Clock at 200 MHz
  initial begin
    clock = 1'h0;
    forever #2.5 clock = ~clock;
  end
  task print_verdict;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : print_verdict
  // Reset for four cycles with new switch settings
  task rst(input logic s, input logic [1:0] l, input logic [1:0] j);
    @(posedge clock);
    resetn <= 1'h0;
    strobe_sel <= s;
    latch_sel <= l;
    attn_sel <= j;
    @(posedge clock);
    periph_u.idle;
    repeat (3) @(posedge clock);
    resetn <= 1'h1;
    // Let the pin filters settle before the first access
    repeat (7) @(posedge clock);
    #1;
  endtask : rst
  task rd(input logic [1:0] a, input logic [7:0] e);
    @(posedge clock);
    io_addr <= a;
    io_rd <= 1'h1;
    #1 rd_v = io_rdata;
    @(posedge clock);
    io_rd <= 1'h0;
    `CHK(rd_v, e)
  endtask : rd
  // One-cycle write pulse, host strobe held n+1 cycles
  task wr(input logic [1:0] a, input logic [7:0] d, input int n);
    @(posedge clock);
    io_addr <= a;
    io_wdata <= d;
    io_wr <= 1'h1;
    io_wr_strobe <= 1'h1;
    @(posedge clock);
    io_wr <= 1'h0;
    repeat (n - 1) @(posedge clock);
    #1 attn_mid = attention;
    @(posedge clock);
    io_wr_strobe <= 1'h0;
    #1;
  endtask : wr
  // Bounded wait for irq (w=0) or output enable (w=1)
  task wait_hi(input bit w);
    int k;
    for (k = 0; k < 20 && (w ? par_out_oe : input_irq) !== 1'h1; k++) @(posedge clock);
    if (k == 20) begin
      fail_count++;
      $display("[FAIL] %0t wait ran out", $time);
    end
    #1;
  endtask : wait_hi
  initial begin
    {resetn, io_rd, io_wr, io_wr_strobe, io_addr, io_wdata} = '0;
    {strobe_sel, oe_sel, attn_sel, latch_sel} = 6'h30;
    fail_count = 0;
    compares = 0;
    // Edge and transparent-pulse capture, both strobe polarities
    for (int i = 0; i < 4; i++) begin
      rst(i[0], {1'h0, i[1]}, 2'h0);
      `CHK(attention, 1'h0)
      rd(2'h3, 8'h00);
      periph_u.send(8'ha5 ^ i[7:0]);
      wait_hi(0);
      rd(2'h3, 8'h01);
      rd(2'h2, 8'ha5 ^ i[7:0]);
      rd(2'h3, 8'h00);
    end
    // Writes to other addresses are ignored
    wr(2'h3, 8'hff, 30);
    wr(2'h0, 8'hff, 30);
    rd(2'h0, 8'h00);
    `CHK(par_out, 8'h00)
    // Level attention, both polarities, handshake by enable
    for (int j = 0; j < 2; j++) begin
      rst(1'h1, 2'h0, j[1:0]);
      `CHK(attention, j[0])
      wr(2'h2, 8'h3c + j[7:0], 30);
      `CHK(attention, !j[0])
      `CHK(par_out, 8'h3c + j[7:0])
      rd(2'h3, 8'h00);
      periph_u.enable(1'h1);
      wait_hi(1);
      repeat (2) @(posedge clock);
      `CHK(attention, j[0])
      rd(2'h3, 8'h02);
      periph_u.enable(1'h0);
    end
    // Pulse attention with outputs kept enabled
    for (int j = 2; j < 4; j++) begin
      rst(1'h1, 2'h0, j[1:0]);
      periph_u.enable(1'h1);
      wait_hi(1);
      wr(2'h2, 8'h81, 30);
      `CHK(attn_mid, !j[0])
      `CHK(attention, j[0])
      `CHK(par_out, 8'h81)
    end
    // Fully transparent: reads follow the lines, no flag
    rst(1'h1, 2'h2, 2'h0);
    periph_u.drive(8'h5a);
    repeat (8) @(posedge clock);
    rd(2'h2, 8'h5a);
    periph_u.drive(8'hc3);
    repeat (8) @(posedge clock);
    rd(2'h2, 8'hc3);
    rd(2'h3, 8'h00);
    print_verdict;
  end
endmodule : lpp_port_tb
